// File: rtl/acc_pkg.sv
/*
 comparator control package: register offsets, field positions, reset values,
 edge mode codes, synchronizer depth and the carrier structs.
 assumes an 8-bit register port addressed by byte offset.
*/
// Functional notes
// - run in standby keeps comparator, freezes flags
// - pad enable drives output onto pin
// - edge field picks both, falling, rising edges
// - hysteresis field passed to analog core
// - enable bit powers comparator; control resets zero
// - invert applies before every output consumer
// - positive select picks pin zero or one
// - negative select picks pin or reference
// - interrupt enable bit at 0x06, resets zero
// - state bit follows output, three cycles
// - flag set on edge, write one clears
// - request while flag and enable both set
// - standby with run bit keeps event and pad updating
// - power-down disables comparator and pad
package acc_pkg;

   // register offsets
   localparam logic [2:0] ACC_OFF_CTRL   = 3'h0;
   localparam logic [2:0] ACC_OFF_MUX    = 3'h2;
   localparam logic [2:0] ACC_OFF_INTEN  = 3'h6;
   localparam logic [2:0] ACC_OFF_STATUS = 3'h7;

   // field positions
   localparam int ACC_BIT_RUNSTBY = 7;
   localparam int ACC_BIT_PADEN   = 6;
   localparam int ACC_BIT_EDGE_HI = 5;
   localparam int ACC_BIT_EDGE_LO = 4;
   localparam int ACC_BIT_HYS_HI  = 2;
   localparam int ACC_BIT_HYS_LO  = 1;
   localparam int ACC_BIT_ENABLE  = 0;
   localparam int ACC_BIT_INVERT  = 7;
   localparam int ACC_BIT_POSSEL  = 3;
   localparam int ACC_BIT_NEG_HI  = 1;
   localparam int ACC_BIT_NEG_LO  = 0;
   localparam int ACC_BIT_IRQEN   = 0;
   localparam int ACC_BIT_STATE   = 4;
   localparam int ACC_BIT_FLAG    = 0;

   // reset values
   localparam logic [7:0] ACC_RST_REG = 8'h00;

   // synchronizer flops ahead of the state bit register
   localparam int ACC_SYNC_STAGES = 2;

   // interrupt edge modes
   typedef enum logic [1:0] {
      ACC_ANY_EDGE  = 2'h0,
      ACC_RESERVED  = 2'h1,
      ACC_FALL_EDGE = 2'h2,
      ACC_RISE_EDGE = 2'h3
   } acc_edge_t;

   // register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } acc_bus_t;

   // settings handed to the analog core
   typedef struct packed {
      logic       enable;
      logic [1:0] hysteresis_select;
      logic       positive_input_select;
      logic [1:0] negative_input_select;
   } acc_analog_t;

endpackage : acc_pkg

// File: rtl/acc_sync.sv
/*
 two-flop synchronizer for the comparator output.
 assumes input is fully asynchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_sync (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset,
   // data
   input  wire logic i_async,
   output logic      o_sync
);
   import acc_pkg::*;

   logic [ACC_SYNC_STAGES-1:0] stage;
   logic [ACC_SYNC_STAGES-1:0] next_stage;

   // shift chain; only the last flop is read outside
   always_comb begin
      next_stage = {stage[ACC_SYNC_STAGES-2:0], i_async};
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         stage <= '0;
      end else begin
         stage <= next_stage;
      end
   end

   assign o_sync = stage[ACC_SYNC_STAGES-1];
endmodule : acc_sync
`default_nettype wire

// File: rtl/acc_top.sv
/*
 comparator control and status wrapper: four byte registers, input and
 hysteresis steering, output inversion, pad drive, edge flag and request.
 assumes the analog core output is asynchronous; i_standby and i_powerdown
 come from the sleep controller as levels; i_clk_gated_off is high while the
 peripheral clock would be stopped (standby with no other clock user).
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
   // clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset,
   // register port
   input  wire acc_pkg::acc_bus_t i_bus,
   output logic [7:0]            o_rdata,
   // sleep status
   input  wire logic             i_standby,
   input  wire logic             i_powerdown,
   input  wire logic             i_clk_gated_off,
   // analog core
   input  wire logic             i_cmp_raw,
   output acc_pkg::acc_analog_t  o_analog,
   // outputs
   output logic                  o_pad_out,
   output logic                  o_pad_oe,
   output logic                  o_event,
   output logic                  o_irq
);
   import acc_pkg::*;

   logic [7:0]  ctrl, next_ctrl;
   logic [7:0]  mux, next_mux;
   logic        irq_en, next_irq_en;
   logic        flag, next_flag;
   logic        state, next_state;
   logic        prev, next_prev;
   logic [7:0]  rdata, next_rdata;
   logic        irq, next_irq;
   acc_analog_t analog, next_analog;
   logic        pad_out, next_pad_out;
   logic        pad_oe, next_pad_oe;
   logic        evt, next_evt;
   logic        cmp_sync;
   logic        cmp_inv;
   logic        frozen;
   logic        active;
   logic        rise, fall, hit;
   acc_edge_t   edge_mode;

   acc_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_async   (i_cmp_raw),
      .o_sync    (cmp_sync)
   );

   // inversion ahead of every consumer
   assign cmp_inv   = cmp_sync ^ mux[ACC_BIT_INVERT];
   assign edge_mode = acc_edge_t'(ctrl[ACC_BIT_EDGE_HI:ACC_BIT_EDGE_LO]);
   // status and flag freeze while the peripheral clock is stopped
   assign frozen = i_standby & i_clk_gated_off;
   // comparator runs while the enable bit is set, unless power-down, or standby without run bit
   assign active = ctrl[ACC_BIT_ENABLE] & ~i_powerdown
                   & ~(i_standby & ~ctrl[ACC_BIT_RUNSTBY]);
   assign rise = cmp_inv & ~prev;
   assign fall = ~cmp_inv & prev;

   // edge selection; reserved code raises nothing
   always_comb begin
      hit = 1'b0;
      unique case (edge_mode)
         ACC_ANY_EDGE:  hit = rise | fall;
         ACC_RESERVED:  hit = 1'b0;
         ACC_FALL_EDGE: hit = fall;
         ACC_RISE_EDGE: hit = rise;
      endcase
   end

   // register writes
   always_comb begin
      next_ctrl   = ctrl;
      next_mux    = mux;
      next_irq_en = irq_en;
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            ACC_OFF_CTRL:  next_ctrl = {i_bus.wdata[7:4], 1'b0, i_bus.wdata[2:0]};
            ACC_OFF_MUX:   next_mux = {i_bus.wdata[7], 3'h0, i_bus.wdata[3], 1'b0, i_bus.wdata[1:0]};
            ACC_OFF_INTEN: next_irq_en = i_bus.wdata[ACC_BIT_IRQEN];
            default:       next_ctrl = ctrl;
         endcase
      end
   end

   // flag and state; a set in the clearing cycle wins
   always_comb begin
      next_flag  = flag;
      next_state = state;
      next_prev  = prev;
      if (i_bus.wr && i_bus.addr == ACC_OFF_STATUS && i_bus.wdata[ACC_BIT_FLAG]) begin
         next_flag = 1'b0;
      end
      if (!frozen) begin
         next_state = cmp_inv;
         next_prev  = cmp_inv;
         if (ctrl[ACC_BIT_ENABLE] && hit) begin
            next_flag = 1'b1;
         end
      end
   end

   // read data, one cycle after the strobe, zero otherwise
   always_comb begin
      next_rdata = 8'h00;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            ACC_OFF_CTRL:   next_rdata = ctrl;
            ACC_OFF_MUX:    next_rdata = mux;
            ACC_OFF_INTEN:  next_rdata = {7'h00, irq_en};
            ACC_OFF_STATUS: next_rdata = {3'h0, state, 3'h0, flag};
            default:        next_rdata = 8'h00;
         endcase
      end
   end

   // outputs, registered; pad and event keep running in standby when the run bit is set
   always_comb begin
      next_irq = next_flag & next_irq_en;
      next_analog.enable                = active;
      next_analog.hysteresis_select     = ctrl[ACC_BIT_HYS_HI:ACC_BIT_HYS_LO];
      next_analog.positive_input_select = mux[ACC_BIT_POSSEL];
      next_analog.negative_input_select = mux[ACC_BIT_NEG_HI:ACC_BIT_NEG_LO];
      next_pad_oe  = active & ctrl[ACC_BIT_PADEN];
      next_pad_out = next_pad_oe & cmp_inv;
      next_evt     = active & cmp_inv;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ctrl    <= ACC_RST_REG;
         mux     <= ACC_RST_REG;
         irq_en  <= 1'b0;
         flag    <= 1'b0;
         state   <= 1'b0;
         prev    <= 1'b0;
         rdata   <= 8'h00;
         irq     <= 1'b0;
         analog  <= '0;
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
         evt     <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         mux     <= next_mux;
         irq_en  <= next_irq_en;
         flag    <= next_flag;
         state   <= next_state;
         prev    <= next_prev;
         rdata   <= next_rdata;
         irq     <= next_irq;
         analog  <= next_analog;
         pad_out <= next_pad_out;
         pad_oe  <= next_pad_oe;
         evt     <= next_evt;
      end
   end

   assign o_rdata   = rdata;
   assign o_irq     = irq;
   assign o_analog  = analog;
   assign o_pad_out = pad_out;
   assign o_pad_oe  = pad_oe;
   assign o_event   = evt;

   // assertions
   property p_irq_pair;
      @(posedge i_clk_sys) disable iff (i_reset)
      ##1 (o_irq == (flag & irq_en));
   endproperty
   a_irq_pair: assert property (p_irq_pair) else $error("irq not flag and enable");

   property p_clear;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_bus.wr && i_bus.addr == ACC_OFF_STATUS && i_bus.wdata[0] && !(ctrl[0] && hit && !frozen))
      |=> !flag;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_zero_keeps;
      @(posedge i_clk_sys) disable iff (i_reset)
      (flag && !(i_bus.wr && i_bus.addr == ACC_OFF_STATUS && i_bus.wdata[0])) |=> flag;
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost");

   property p_state_delay;
      @(posedge i_clk_sys) disable iff (i_reset)
      (!$past(frozen) && $stable(mux[ACC_BIT_INVERT]))
      |-> (state == ($past(i_cmp_raw, 3) ^ mux[ACC_BIT_INVERT]));
   endproperty
   a_state_delay: assert property (p_state_delay) else $error("state lag wrong");

   property p_freeze;
      @(posedge i_clk_sys) disable iff (i_reset)
      frozen |=> (state == $past(state));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_powerdown;
      @(posedge i_clk_sys) disable iff (i_reset)
      i_powerdown |=> (!o_pad_oe && !o_analog.enable);
   endproperty
   a_powerdown: assert property (p_powerdown) else $error("active in power-down");

   property p_rise_only;
      @(posedge i_clk_sys) disable iff (i_reset)
      (edge_mode == ACC_RISE_EDGE && fall && !rise && !flag) |=> !flag;
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("falling edge set flag");

   property p_pad;
      @(posedge i_clk_sys) disable iff (i_reset)
      (ctrl[0] && ctrl[6] && !i_powerdown && !i_standby) |=> o_pad_oe;
   endproperty
   a_pad: assert property (p_pad) else $error("pad not driven");

   // register port answers
   property p_status_read;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_bus.rd && i_bus.addr == ACC_OFF_STATUS) |=> (o_rdata == {3'h0, $past(state), 3'h0, $past(flag)});
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_inten_write;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_bus.wr && i_bus.addr == ACC_OFF_INTEN) |=> (irq_en == $past(i_bus.wdata[ACC_BIT_IRQEN]));
   endproperty
   a_inten_write: assert property (p_inten_write) else $error("interrupt enable not stored");

   // settings reach the analog core one cycle later
   property p_hys;
      @(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_analog.hysteresis_select == $past(ctrl[ACC_BIT_HYS_HI:ACC_BIT_HYS_LO]));
   endproperty
   a_hys: assert property (p_hys) else $error("hysteresis not passed on");

   property p_route;
      @(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_analog.positive_input_select == $past(mux[ACC_BIT_POSSEL])
                && o_analog.negative_input_select == $past(mux[ACC_BIT_NEG_HI:ACC_BIT_NEG_LO]));
   endproperty
   a_route: assert property (p_route) else $error("input select not passed on");

   property p_enable_off;
      @(posedge i_clk_sys) disable iff (i_reset)
      !ctrl[ACC_BIT_ENABLE] |=> !o_analog.enable;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("core on while disabled");

   // standby: halted without the run bit, running with it
   property p_halt;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_standby && !ctrl[ACC_BIT_RUNSTBY]) |=> !o_analog.enable;
   endproperty
   a_halt: assert property (p_halt) else $error("core on in standby");

   property p_run_standby;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_standby && !i_powerdown && ctrl[ACC_BIT_RUNSTBY] && ctrl[ACC_BIT_ENABLE]) |=> o_analog.enable;
   endproperty
   a_run_standby: assert property (p_run_standby) else $error("core off with run bit");

   // inverted, synced compare feeds event and pad alike
   property p_event;
      @(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_event == ($past(active) && ($past(cmp_sync) ^ $past(mux[ACC_BIT_INVERT]))));
   endproperty
   a_event: assert property (p_event) else $error("event level wrong");

   property p_pad_level;
      @(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_pad_out == ($past(active) && $past(ctrl[ACC_BIT_PADEN])
                              && ($past(cmp_sync) ^ $past(mux[ACC_BIT_INVERT]))));
   endproperty
   a_pad_level: assert property (p_pad_level) else $error("pad level wrong");

   // flag only moves up on a selected edge
   property p_set;
      @(posedge i_clk_sys) disable iff (i_reset)
      (ctrl[ACC_BIT_ENABLE] && hit && !frozen) |=> flag;
   endproperty
   a_set: assert property (p_set) else $error("edge did not set flag");

   property p_edge_only;
      @(posedge i_clk_sys) disable iff (i_reset)
      (!flag && !hit) |=> !flag;
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("flag set without edge");

   property p_fall_only;
      @(posedge i_clk_sys) disable iff (i_reset)
      (edge_mode == ACC_FALL_EDGE && rise && !flag) |=> !flag;
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("rising edge set flag");

   property p_reserved;
      @(posedge i_clk_sys) disable iff (i_reset)
      (edge_mode == ACC_RESERVED && !flag) |=> !flag;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode set flag");

   property p_frozen_flag;
      @(posedge i_clk_sys) disable iff (i_reset)
      (frozen && !flag) |=> !flag;
   endproperty
   a_frozen_flag: assert property (p_frozen_flag) else $error("flag set while frozen");

   c_flag_set: cover property (@(posedge i_clk_sys) disable iff (i_reset) !flag ##1 flag);
   c_irq: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_irq ##[1:20] !o_irq);
   c_standby: cover property (@(posedge i_clk_sys) disable iff (i_reset) frozen && o_event);
   c_powerdown: cover property (@(posedge i_clk_sys) disable iff (i_reset) i_powerdown && ctrl[ACC_BIT_PADEN]);
endmodule : acc_top
`default_nettype wire

// File: verification/acc_core_model.sv
/*
 behavioural analog comparator core with its input muxes.
 assumes pin voltages come from the bench as 8-bit codes, vref on neg[2].
*/
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
   // settings from the wrapper
   input  wire acc_pkg::acc_analog_t i_analog,
   // pin voltages
   input  wire logic [1:0][7:0]      i_pos,
   input  wire logic [2:0][7:0]      i_neg,
   // raw compare
   output logic                      o_cmp
);
   import acc_pkg::*;
   logic [7:0] p;
   logic [7:0] n;

   // reserved negative code compares against zero, no hysteresis model
   always_comb begin
      p = i_pos[i_analog.positive_input_select];
      n = (i_analog.negative_input_select == 2'h3) ? 8'h00
          : i_neg[i_analog.negative_input_select];
      o_cmp = i_analog.enable & (p > n);
   end
endmodule : acc_core_model
`default_nettype wire

// File: verification/testbench.sv
/*
 self-checking bench for the comparator wrapper: register tasks and scenarios.
 assumes the core model on the analog side and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acc_pkg::*;
   logic            i_clk_sys = 1'b0;
   logic            i_reset   = 1'b1;
   acc_bus_t        bus       = '0;
   logic            stby      = 1'b0;
   logic            pdn       = 1'b0;
   logic            gate      = 1'b0;
   logic [1:0][7:0] pos       = 16'h4040;
   logic [2:0][7:0] neg       = 24'h808080;
   logic            cmp, pad, oe, evt, irq;
   logic [7:0]      rdata, v;
   acc_analog_t     ana;
   logic [2:0]      offs [5]  = '{3'h0, 3'h2, 3'h6, 3'h7, 3'h1};
   logic [3:0]      rise      = 4'b1001;
   logic [3:0]      fall      = 4'b0101;
   int              failures  = 0;
   int              samples_checked = 0;

   acc_top dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
      .i_standby(stby), .i_powerdown(pdn), .i_clk_gated_off(gate), .i_cmp_raw(cmp),
      .o_analog(ana), .o_pad_out(pad), .o_pad_oe(oe), .o_event(evt), .o_irq(irq));
   acc_core_model core (.i_analog(ana), .i_pos(pos), .i_neg(neg), .o_cmp(cmp));

   // free-running system clock
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   task automatic report_and_stop;
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // gap after each strobe so no signal is assigned twice in one step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      bus.wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask : wr

   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      bus.rd <= 1'b0;
      #1 v = rdata;
      chk(n, e, v);
      @(posedge i_clk_sys);
   endtask : rc

   // compare level via positive pin one against the reference
   task automatic sc(input logic b);
      pos[1] <= b ? 8'hC0 : 8'h40;
      repeat (6) @(posedge i_clk_sys);
   endtask : sc

   // hang guard
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
      foreach (offs[i]) rc(offs[i], 8'h00, "reset");
      wr(ACC_OFF_CTRL, 8'hFF);
      rc(ACC_OFF_CTRL, 8'hF7, "ctrl");
      chk("analog", 8'h38, 8'(ana));
      chk("pad_oe", 8'h01, {7'h0, oe});
      wr(ACC_OFF_MUX, 8'hFF);
      rc(ACC_OFF_MUX, 8'h8B, "mux");
      wr(ACC_OFF_MUX, 8'h0A);
      @(negedge i_clk_sys);
      chk("analog", 8'h3E, 8'(ana));
      @(posedge i_clk_sys);
      wr(ACC_OFF_INTEN, 8'hFF);
      rc(ACC_OFF_INTEN, 8'h01, "inten");
      // every edge mode code, reserved one included
      for (int m = 0; m < 4; m++) begin
         wr(ACC_OFF_CTRL, 8'h41 | 8'(m << 4));
         wr(ACC_OFF_STATUS, 8'h01);
         sc(1'b1);
         rc(ACC_OFF_STATUS, 8'h10 | {7'h0, rise[m]}, "rise");
         chk("irq", {7'h0, rise[m]}, {7'h0, irq});
         chk("pad", 8'h01, {7'h0, pad});
         wr(ACC_OFF_STATUS, 8'h01);
         sc(1'b0);
         rc(ACC_OFF_STATUS, {7'h0, fall[m]}, "fall");
         chk("irq", {7'h0, fall[m]}, {7'h0, irq});
      end
      wr(ACC_OFF_CTRL, 8'h41);
      sc(1'b1);
      wr(ACC_OFF_STATUS, 8'h00);
      rc(ACC_OFF_STATUS, 8'h11, "keep");
      wr(ACC_OFF_STATUS, 8'h01);
      rc(ACC_OFF_STATUS, 8'h10, "clear");
      chk("irq", 8'h00, {7'h0, irq});
      wr(ACC_OFF_MUX, 8'h8A);
      repeat (6) @(posedge i_clk_sys);
      rc(ACC_OFF_STATUS, 8'h01, "invert");
      sc(1'b0);
      chk("pad", 8'h01, {7'h0, pad});
      chk("event", 8'h01, {7'h0, evt});
      wr(ACC_OFF_STATUS, 8'h01);
      wr(ACC_OFF_CTRL, 8'hC1);
      stby <= 1'b1;
      gate <= 1'b1;
      sc(1'b1);
      chk("event", 8'h00, {7'h0, evt});
      chk("pad", 8'h00, {7'h0, pad});
      chk("irq", 8'h00, {7'h0, irq});
      wr(ACC_OFF_CTRL, 8'h41);
      repeat (4) @(posedge i_clk_sys);
      chk("halted", 8'h00, {7'h0, ana.enable});
      stby <= 1'b0;
      gate <= 1'b0;
      pdn  <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      chk("pd_oe", 8'h00, {7'h0, oe});
      chk("pd_en", 8'h00, {7'h0, ana.enable});
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
